/* File: logic/occ_defs.svh */
// register offsets, field positions, reset values for the oscillator control block
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
`define OCC_ADDR_SYS_CLOCK     12'h000
`define OCC_ADDR_FAST_RC       12'h004
`define OCC_ADDR_FAST_XTAL     12'h008
`define OCC_ADDR_SLOW_XTAL     12'h00c
`define OCC_ADDR_POWER_STATUS  12'h010
`define OCC_ADDR_HALT_CMD      12'h014
`define OCC_SCC_RESET          8'h00
`define OCC_RC_RESET           8'h01
`define OCC_XT_RESET           8'h00
`define OCC_SEL_SLOW           3'h7
`define OCC_STAT_PDF_BIT       0
`define OCC_STAT_TO_BIT        1
`define OCC_MODE_BIT           4
`endif

/* File: logic/occ_osc_control.sv */
// oscillator control and power mode logic with apb register access
// Summary of operation
// - new fast rc frequency applied only after its stable flag rises
// - enabling or retuning fast rc clears its stable flag until stable again
// - fast rc control bit 0 enables the fast rc oscillator
// - crystal drive bit 2: 0 low drive up to 10MHz, 1 high drive
// - drive bit write ignored while crystal pins enabled and crystal on
// - enabling fast crystal clears its stable flag until stable
// - slow crystal bit 2 selects speed-up start versus low power
// - speed-up bit frozen once slow crystal is the system clock
// - enabling slow crystal clears its stable flag until stable
// - bits 7 to 3 of crystal control registers read as zero
// - select 111 moves system clock to slow source once it is stable
// - select 000 to 110 gives high clock divided by 1 to 64
// - halt picks sleep or idle from the two keep bits
// - halt with both keep bits 0 enters sleep, all clocks stopped
// - halt with only low keep bit enters idle-zero, high clock off
// - halt with both keep bits 1 enters idle-one, both clocks run
// - sleep and idle leave memory, registers and ports untouched
// - sleep or idle entry sets power-down flag, clears timeout flag
// - halt entry clears watchdog, counting on only when enabled
// - fast rc field 00 8MHz, 01 12MHz, 10 16MHz, 11 8MHz
// - high source bit picks rc or crystal; low source bit likewise
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "occ_defs.svh"
module occ_osc_control (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        fast_rc_ready_i,
  input  wire logic        fast_crystal_ready_i,
  input  wire logic        slow_crystal_ready_i,
  input  wire logic        crystal_pins_enabled_i,
  input  wire logic        watchdog_enabled_i,
  input  wire logic        halt_i,
  input  wire logic        wake_i,
  output logic             fast_rc_osc_en_o,
  output logic [1:0]       fast_rc_freq_o,
  output logic             fast_crystal_osc_en_o,
  output logic             fast_crystal_drive_mode_o,
  output logic             slow_crystal_osc_en_o,
  output logic             slow_crystal_speedup_o,
  output logic             high_speed_clock_en_o,
  output logic             low_speed_clock_en_o,
  output logic             sys_clock_en_o,
  output logic             sys_on_slow_o,
  output logic             high_source_o,
  output logic             low_source_o,
  output logic [2:0]       high_div_o,
  output logic             watchdog_clear_o,
  output logic             watchdog_hold_o,
  output logic             power_down_flag_o,
  output logic             timeout_flag_o
);
  logic [7:0] scc_ff;
  logic [3:0] rc_ff;
  logic [2:0] hxt_ff;
  logic [2:0] lxt_ff;
  logic       rc_unstable_ff;
  logic       hxt_unstable_ff;
  logic       lxt_unstable_ff;
  logic [1:0] rc_freq_active_ff;
  logic       on_slow_ff;
  logic [2:0] div_ff;
  logic       high_src_ff;
  logic       low_src_ff;
  logic       pdf_ff;
  logic       to_ff;
  logic       wdt_clr_ff;
  logic       wdt_hold_ff;
  logic [31:0] rdata_ff;
  logic       slverr_ff;
  logic       ready_ff;
  occ_pkg::occ_mode_type mode_ff;
  occ_pkg::occ_mode_type nxt_mode;
  logic       wr;
  logic       acc_done;
  logic       wr_scc;
  logic       wr_rc;
  logic       wr_hxt;
  logic       wr_lxt;
  logic       wr_stat;
  logic       halt_entry;
  logic       slow_req;
  logic       rd_phase;
  logic       rc_stable;
  logic       hxt_stable;
  logic       lxt_stable;
  logic       high_stable;
  logic       low_stable;
  logic       mapped;
  logic [31:0] nxt_rdata;

  // single wait state: ready rises in the second access cycle
  assign rd_phase  = psel_i & penable_i & ~ready_ff;
  // writes commit on the edge that samples pready, never before the answer
  assign acc_done  = psel_i & penable_i & ready_ff;
  assign wr        = acc_done & pwrite_i;
  // one strobe per register, decoded once
  assign wr_scc    = wr & (paddr_i == `OCC_ADDR_SYS_CLOCK);
  assign wr_rc     = wr & (paddr_i == `OCC_ADDR_FAST_RC);
  assign wr_hxt    = wr & (paddr_i == `OCC_ADDR_FAST_XTAL);
  assign wr_lxt    = wr & (paddr_i == `OCC_ADDR_SLOW_XTAL);
  assign wr_stat   = wr & (paddr_i == `OCC_ADDR_POWER_STATUS);
  assign rc_stable  = rc_ff[0] & ~rc_unstable_ff & fast_rc_ready_i;
  assign hxt_stable = hxt_ff[0] & ~hxt_unstable_ff & fast_crystal_ready_i;
  assign lxt_stable = lxt_ff[0] & ~lxt_unstable_ff & slow_crystal_ready_i;
  assign high_stable = scc_ff[3] ? hxt_stable : rc_stable;
  assign low_stable  = scc_ff[2] ? lxt_stable : 1'b1;
  assign slow_req    = scc_ff[7:5] == `OCC_SEL_SLOW;
  assign mapped = (paddr_i == `OCC_ADDR_SYS_CLOCK) | (paddr_i == `OCC_ADDR_FAST_RC) |
                  (paddr_i == `OCC_ADDR_FAST_XTAL) | (paddr_i == `OCC_ADDR_SLOW_XTAL) |
                  (paddr_i == `OCC_ADDR_POWER_STATUS) | (paddr_i == `OCC_ADDR_HALT_CMD);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ready_ff  <= 1'b0;
      slverr_ff <= 1'b0;
    end else begin
      ready_ff  <= rd_phase;
      slverr_ff <= rd_phase & ~mapped;
    end
  end

  // system clock select register, bit 4 reserved
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scc_ff <= `OCC_SCC_RESET;
    end else if (wr_scc) begin
      scc_ff <= {pwdata_i[7:5], 1'b0, pwdata_i[3:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rc_ff <= 4'(`OCC_RC_RESET);
    end else if (wr_rc) begin
      rc_ff <= {pwdata_i[3:2], 1'b0, pwdata_i[0]};
    end
  end

  // restart on enable or retune
  // clears only once ready has been seen low after the restart
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rc_unstable_ff <= 1'b1;
    end else if (wr_rc &&
                 ((pwdata_i[0] && !rc_ff[0]) || pwdata_i[3:2] != rc_ff[3:2])) begin
      rc_unstable_ff <= 1'b1;
    end else if (!fast_rc_ready_i) begin
      rc_unstable_ff <= 1'b0;
    end
  end

  // frequency takes effect after stable
  // held while retuning so the divider never sees a half-settled clock
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rc_freq_active_ff <= 2'h0;
    end else if (rc_stable) begin
      rc_freq_active_ff <= rc_ff[3:2];
    end
  end

  // drive mode, locked while pins used and crystal on
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hxt_ff <= 3'(`OCC_XT_RESET);
    end else if (wr_hxt) begin
      hxt_ff[0] <= pwdata_i[0];
      if (!(crystal_pins_enabled_i && hxt_ff[0])) begin
        hxt_ff[2] <= pwdata_i[2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hxt_unstable_ff <= 1'b1;
    end else if (wr_hxt && pwdata_i[0] && !hxt_ff[0]) begin
      hxt_unstable_ff <= 1'b1;
    end else if (!fast_crystal_ready_i) begin
      hxt_unstable_ff <= 1'b0;
    end
  end

  // speed-up, frozen while slow crystal drives the system
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lxt_ff <= 3'(`OCC_XT_RESET);
    end else if (wr_lxt) begin
      lxt_ff[0] <= pwdata_i[0];
      if (!(on_slow_ff && low_src_ff)) begin
        lxt_ff[2] <= pwdata_i[2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lxt_unstable_ff <= 1'b1;
    end else if (wr_lxt && pwdata_i[0] && !lxt_ff[0]) begin
      lxt_unstable_ff <= 1'b1;
    end else if (!slow_crystal_ready_i) begin
      lxt_unstable_ff <= 1'b0;
    end
  end

  // handover only when target is stable, one edge at a time
  // slow switch waits for stable slow source
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      on_slow_ff  <= 1'b0;
      div_ff      <= 3'h0;
      high_src_ff <= 1'b0;
      low_src_ff  <= 1'b0;
    end else if (slow_req) begin
      if (!on_slow_ff || low_src_ff != scc_ff[2]) begin
        if (low_stable) begin
          on_slow_ff <= 1'b1;
          low_src_ff <= scc_ff[2];
        end
      end
    end else if (high_stable) begin
      on_slow_ff  <= 1'b0;
      div_ff      <= scc_ff[7:5];
      high_src_ff <= scc_ff[3];
    end
  end

  // halt mode chosen by keep bits
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      occ_pkg::OCC_RUN: begin
        if (halt_i) begin
          unique case (scc_ff[1:0])
            2'b00: nxt_mode = occ_pkg::OCC_SLEEP;
            2'b01: nxt_mode = occ_pkg::OCC_IDLE_ZERO;
            2'b11: nxt_mode = occ_pkg::OCC_IDLE_ONE;
            // third idle mode lives outside, stay running
            default: nxt_mode = occ_pkg::OCC_RUN;
          endcase
        end
      end
      occ_pkg::OCC_SLEEP,
      occ_pkg::OCC_IDLE_ZERO,
      occ_pkg::OCC_IDLE_ONE: begin
        if (wake_i) begin
          nxt_mode = occ_pkg::OCC_RUN;
        end
      end
      default: nxt_mode = occ_pkg::OCC_RUN;
    endcase
  end

  // only the mode changes; registers are left as they are
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_ff <= occ_pkg::OCC_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // single-cycle marker of the step from run to halted
  assign halt_entry = mode_ff == occ_pkg::OCC_RUN && nxt_mode != occ_pkg::OCC_RUN;

  // power-down set, timeout cleared on entry
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pdf_ff <= 1'b0;
      to_ff  <= 1'b0;
    end else if (halt_entry) begin
      pdf_ff <= 1'b1;
      to_ff  <= 1'b0;
    end else if (wr_stat) begin
      pdf_ff <= pwdata_i[`OCC_STAT_PDF_BIT];
      to_ff  <= pwdata_i[`OCC_STAT_TO_BIT];
    end
  end

  // watchdog cleared at entry, held when disabled
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wdt_clr_ff  <= 1'b0;
      wdt_hold_ff <= 1'b0;
    end else begin
      wdt_clr_ff  <= halt_entry;
      wdt_hold_ff <= nxt_mode != occ_pkg::OCC_RUN && !watchdog_enabled_i;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0;
    unique case (paddr_i)
      `OCC_ADDR_SYS_CLOCK:    nxt_rdata = {24'h0, scc_ff};
      `OCC_ADDR_FAST_RC:      nxt_rdata = {28'h0, rc_ff[3:2], rc_stable, rc_ff[0]};
      `OCC_ADDR_FAST_XTAL:    nxt_rdata = {29'h0, hxt_ff[2], hxt_stable, hxt_ff[0]};
      `OCC_ADDR_SLOW_XTAL:    nxt_rdata = {29'h0, lxt_ff[2], lxt_stable, lxt_ff[0]};
      `OCC_ADDR_POWER_STATUS: nxt_rdata = {24'h0, mode_ff, on_slow_ff, 1'b0, to_ff, pdf_ff};
      default:                nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0;
    end else if (rd_phase && !pwrite_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // clock gates registered; a true glitch-free gate sits in the clock tree
  logic hs_en_ff;
  logic ls_en_ff;
  logic sys_en_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hs_en_ff  <= 1'b1;
      ls_en_ff  <= 1'b1;
      sys_en_ff <= 1'b1;
    end else begin
      hs_en_ff  <= nxt_mode == occ_pkg::OCC_RUN || nxt_mode == occ_pkg::OCC_IDLE_ONE;
      ls_en_ff  <= nxt_mode != occ_pkg::OCC_SLEEP;
      sys_en_ff <= nxt_mode == occ_pkg::OCC_RUN;
    end
  end

  assign prdata_o                  = rdata_ff;
  assign pready_o                  = ready_ff;
  assign pslverr_o                 = slverr_ff;
  assign fast_rc_osc_en_o          = rc_ff[0];
  assign fast_rc_freq_o            = rc_freq_active_ff;
  assign fast_crystal_osc_en_o     = hxt_ff[0];
  assign fast_crystal_drive_mode_o = hxt_ff[2];
  assign slow_crystal_osc_en_o     = lxt_ff[0];
  assign slow_crystal_speedup_o    = lxt_ff[2];
  assign high_speed_clock_en_o     = hs_en_ff;
  assign low_speed_clock_en_o      = ls_en_ff;
  assign sys_clock_en_o            = sys_en_ff;
  assign sys_on_slow_o             = on_slow_ff;
  assign high_source_o             = high_src_ff;
  assign low_source_o              = low_src_ff;
  assign high_div_o                = div_ff;
  assign watchdog_clear_o          = wdt_clr_ff;
  assign watchdog_hold_o           = wdt_hold_ff;
  assign power_down_flag_o         = pdf_ff;
  assign timeout_flag_o            = to_ff;
endmodule
`default_nettype wire

/* File: logic/occ_pkg.sv */
// types shared by the oscillator control block
package occ_pkg;
  typedef enum logic [3:0] {
    OCC_RUN        = 4'h1,
    OCC_SLEEP      = 4'h2,
    OCC_IDLE_ZERO  = 4'h4,
    OCC_IDLE_ONE   = 4'h8
  } occ_mode_type;
endpackage

/* File: sim/occ_osc_control_checker.sv */
// port assertions for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module occ_osc_control_checker (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       halt_i,
  input wire logic       watchdog_clear_o,
  input wire logic       power_down_flag_o,
  input wire logic       timeout_flag_o,
  input wire logic       high_speed_clock_en_o,
  input wire logic       low_speed_clock_en_o,
  input wire logic       sys_clock_en_o,
  input wire logic       crystal_pins_enabled_i,
  input wire logic       fast_crystal_osc_en_o,
  input wire logic       fast_crystal_drive_mode_o,
  input wire logic       sys_on_slow_o,
  input wire logic       low_source_o,
  input wire logic       slow_crystal_speedup_o,
  input wire logic [1:0] fast_rc_freq_o,
  input wire logic       fast_rc_ready_i,
  input wire logic       slow_crystal_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_ready; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("no answer after one wait state");
  property p_halt_flags; watchdog_clear_o |-> power_down_flag_o && !timeout_flag_o; endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_clr_cause; watchdog_clear_o |-> $past(halt_i); endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("watchdog clear without halt");
  property p_clr_pulse; watchdog_clear_o |=> !watchdog_clear_o; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("watchdog clear too long");
  property p_sleep; watchdog_clear_o && !low_speed_clock_en_o |-> !high_speed_clock_en_o && !sys_clock_en_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left a clock on");
  property p_drive; crystal_pins_enabled_i && fast_crystal_osc_en_o |=> $stable(fast_crystal_drive_mode_o);
  endproperty
  a_drive: assert property (p_drive) else $error("drive mode changed while locked");
  property p_speedup; sys_on_slow_o && low_source_o |=> $stable(slow_crystal_speedup_o); endproperty
  a_speedup: assert property (p_speedup) else $error("speed-up changed on slow crystal");
  property p_freq; !$stable(fast_rc_freq_o) |-> $past(fast_rc_ready_i); endproperty
  a_freq: assert property (p_freq) else $error("rc frequency applied while unstable");
  property p_slow; $rose(sys_on_slow_o) |-> !low_source_o || $past(slow_crystal_ready_i); endproperty
  a_slow: assert property (p_slow) else $error("slow switch before crystal stable");
  c_halt: cover property (watchdog_clear_o);
  c_slow: cover property ($rose(sys_on_slow_o));
  c_lock: cover property (crystal_pins_enabled_i && fast_crystal_osc_en_o);
endmodule
bind occ_osc_control occ_osc_control_checker u_chk (.clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o, .halt_i,
  .watchdog_clear_o, .power_down_flag_o, .timeout_flag_o, .high_speed_clock_en_o, .low_speed_clock_en_o,
  .sys_clock_en_o, .crystal_pins_enabled_i, .fast_crystal_osc_en_o, .fast_crystal_drive_mode_o, .sys_on_slow_o,
  .low_source_o, .slow_crystal_speedup_o, .fast_rc_freq_o, .fast_rc_ready_i, .slow_crystal_ready_i);
`default_nettype wire

/* File: sim/occ_osc_model.sv */
// behavioural oscillator answering enable and retune
`timescale 1ns/10ps
`default_nettype none
module occ_osc_model #(
  parameter int DLY = 6
) (
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic kick_i,
  output logic      ready_o
);
  int cnt_ff = DLY;
  always @(posedge clk_i) begin
    if (!en_i || kick_i) begin
      cnt_ff <= DLY;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  // no output when stopped, never the stale level
  assign ready_o = en_i && (cnt_ff == 0);
endmodule
`default_nettype wire

/* File: sim/osc_control_and_power_modes_tb_top.sv */
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module osc_control_and_power_modes_tb_top;
  logic        clk_i, rst_b_i, psel, penable, pwrite, pins, wden, halt, wake, kick;
  logic        pready, pslverr, rcr, fxr, sxr, rcen, fxen, fxdm, sxen, sxsp, hsen, lsen, sysen;
  logic        onslow, hsrc, lsrc, wdclr, wdhold, power_down_flag, tof;
  logic [1:0]  rcf;
  logic [2:0]  div;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [33:0] qe;
  logic [33:0] q[$];
  int          miscompares, comparisons, prev;
  occ_osc_control uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .fast_rc_ready_i(rcr), .fast_crystal_ready_i(fxr), .slow_crystal_ready_i(sxr), .crystal_pins_enabled_i(pins),
    .watchdog_enabled_i(wden), .halt_i(halt), .wake_i(wake), .fast_rc_osc_en_o(rcen), .fast_rc_freq_o(rcf),
    .fast_crystal_osc_en_o(fxen), .fast_crystal_drive_mode_o(fxdm), .slow_crystal_osc_en_o(sxen),
    .slow_crystal_speedup_o(sxsp), .high_speed_clock_en_o(hsen), .low_speed_clock_en_o(lsen),
    .sys_clock_en_o(sysen), .sys_on_slow_o(onslow), .high_source_o(hsrc), .low_source_o(lsrc), .high_div_o(div),
    .watchdog_clear_o(wdclr), .watchdog_hold_o(wdhold), .power_down_flag_o(power_down_flag), .timeout_flag_o(tof));
  occ_osc_model m_rc (.clk_i(clk_i), .en_i(rcen), .kick_i(kick), .ready_o(rcr));
  occ_osc_model m_fx (.clk_i(clk_i), .en_i(fxen), .kick_i(1'b0), .ready_o(fxr));
  occ_osc_model #(.DLY(12)) m_sx (.clk_i(clk_i), .en_i(sxen), .kick_i(1'b0), .ready_o(sxr));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // request held until pready is sampled, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic er = 1'b0);
    int n;
    q.push_back({~w, er, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      final_report;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  always @(posedge clk_i) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        $display("MISMATCH apb_queue exp 1 seen 0");
        miscompares++;
      end else begin
        qe = q.pop_front();
        chk("pslverr", {31'h0, qe[32]}, {31'h0, pslverr});
        if (qe[33]) chk("prdata", qe[31:0], prdata);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report;
  end
  initial begin
    {psel, penable, pwrite, pins, wden, halt, wake, kick} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst_b_i = 1'b0;
    miscompares = 0;
    comparisons = 0;
    prev = 0;
    rnd = $urandom(16);
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h0);
    apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
    cyc(8);
    rd(12'h004, 32'h3);
    pins <= 1'b1;
    rnd = $urandom;
    wr(12'h008, (rnd & ~32'h7) | 32'h4);
    wr(12'h008, (rnd & ~32'h7) | 32'h5);
    rd(12'h008, 32'h5);
    chk("drive", 32'h1, {31'h0, fxdm});
    cyc(10);
    rd(12'h008, 32'h7);
    wr(12'h008, 32'h1);
    rd(12'h008, 32'h7);
    pins <= 1'b0;
    wr(12'h008, 32'h1);
    rd(12'h008, 32'h3);
    wr(12'h008, 32'h0);
    rd(12'h008, 32'h0);
    // last pass leaves the 00 choice
    for (int f = 3; f >= 0; f--) begin
      wr(12'h004, f * 4 + 1);
      kick <= 1'b1;
      @(posedge clk_i);
      kick <= 1'b0;
      rd(12'h004, f * 4 + 1);
      chk("rc_freq_hold", prev, {30'h0, rcf});
      cyc(10);
      rd(12'h004, f * 4 + 3);
      chk("rc_freq", f, {30'h0, rcf});
      prev = f;
    end
    wr(12'h00c, 32'h5);
    wr(12'h000, 32'he4);
    chk("on_slow_early", 32'h0, {31'h0, onslow});
    cyc(20);
    chk("on_slow", 32'h1, {31'h0, onslow});
    chk("low_src", 32'h1, {31'h0, lsrc});
    wr(12'h00c, 32'h1);
    rd(12'h00c, 32'h7);
    chk("speedup", 32'h1, {31'h0, sxsp});
    for (int d = 0; d < 7; d++) begin
      wr(12'h000, d << 5);
      cyc(4);
      chk("div", d, {29'h0, div});
      chk("fast_again", 32'h0, {31'h0, onslow});
      chk("high_src", 32'h0, {31'h0, hsrc});
    end
    for (int k = 0; k < 4; k++) begin
      wden <= (k != 0);
      wr(12'h010, 32'h2);
      wr(12'h000, k);
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      @(negedge clk_i);
      chk("wd_clr", k != 2, {31'h0, wdclr});
      if (k != 2) begin
        chk("pdf", 32'h1, {31'h0, power_down_flag});
        chk("to", 32'h0, {31'h0, tof});
        chk("hs_en", k == 3, {31'h0, hsen});
        chk("ls_en", k != 0, {31'h0, lsen});
      end
      if (k != 2) chk("sys_en", 32'h0, {31'h0, sysen});
      chk("wd_hold", k == 0, {31'h0, wdhold});
      @(posedge clk_i);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      cyc(2);
      rd(12'h010, (k == 2) ? 32'h12 : 32'h11);
      rd(12'h000, k);
    end
    final_report;
  end
endmodule
`default_nettype wire
